// file: src/ccs_pkg.sv
// Constants, types and lookup functions of the CPU clock select block.
// Functional notes
// - Clock mode strapped from config pins at reset.
// - Code 001: CPU clock is input halved.
// - Prescaler half-period equals one input period.
// - Code 011: CPU follows input; PLL runs only for the watchdog.
// - Other codes: PLL multiplies by coded factor.
// - PLL resynchronises to input every F transitions.
// - Both CPU clock edges mark timing units.
// - Direct drive: two half-periods equal input period.
// - Watchdog only in direct or prescaler mode.
// - Watchdog enabled after reset; bit 4 disables.
// - Free PLL clock counts; input transition clears.
// - Sixteen free clocks without transition: fail over.
// - Failover is sticky until hardware reset.
// - Watchdog disabled: oscillator feeds CPU, PLL off.
package ccs_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SYS_CFG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int OWD_DISABLE_BIT = 4;
  localparam logic SYS_CFG_RESET = 1'b0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_FAILED_BIT = 3;
  localparam int STAT_PLL_BIT = 4;
  localparam int STAT_IRQ_BIT = 5;
  // ****************************************
  // Configuration codes
  // ****************************************
  localparam logic [2:0] CFG_PRESC = 3'h1;
  localparam logic [2:0] CFG_DIRECT = 3'h3;
  localparam logic [2:0] CFG_RESET = 3'h7;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 40000;
  localparam int PLL_FREE_HALF_NS = 50;
  localparam logic [2:0] PLL_FREE_HALF_CYC =
    3'((PLL_FREE_HALF_NS * CLK_KHZ + 999999) / 1000000);
  localparam logic [4:0] WD_OVERFLOW = 5'h10;
  localparam logic [1:0] STRAP_DELAY = 2'h3;
  typedef enum logic [1:0] {
    SRC_HOLD = 2'b00,
    SRC_OSC = 2'b01,
    SRC_PLL = 2'b10,
    SRC_FREE = 2'b11
  } ccs_src_t;
  // Twice the multiplication factor, so that 1.5 and 2.5 stay integral.
  function automatic logic [3:0] ccs_mult2(input logic [2:0] code);
    case (code)
      3'h7: ccs_mult2 = 4'h8;
      3'h6: ccs_mult2 = 4'h6;
      3'h5: ccs_mult2 = 4'h4;
      3'h4: ccs_mult2 = 4'ha;
      3'h2: ccs_mult2 = 4'h3;
      3'h0: ccs_mult2 = 4'h5;
      default: ccs_mult2 = 4'h2;
    endcase
  endfunction
  // Input transitions between resyncs; fractional factors use two.
  function automatic logic [2:0] ccs_resync(input logic [2:0] code);
    case (code)
      3'h7: ccs_resync = 3'h4;
      3'h6: ccs_resync = 3'h3;
      3'h4: ccs_resync = 3'h5;
      default: ccs_resync = 3'h2;
    endcase
  endfunction
endpackage

// file: src/ccs_ctrl_if.sv
// Control and status bundle between the register slave and the core.
`timescale 1ns/1ps
interface ccs_ctrl_if;
  logic owd_disable;
  logic irq_flag;
  logic fail_event;
  logic failed;
  logic pll_on;
  logic [2:0] mode;
  modport regs (output owd_disable, irq_flag,
                input fail_event, failed, pll_on, mode);
  modport core (input owd_disable, irq_flag,
                output fail_event, failed, pll_on, mode);
endinterface

// file: src/ccs_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module ccs_sync #(
  parameter int W = 1
) (
  // Clocking
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;
  always_comb
  begin
    meta_next = ce ? d : meta_reg;
    q_next = ce ? meta_reg : q;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule // ccs_sync

// file: src/ccs_regs.sv
// Classic Wishbone slave with the configuration and status registers.
`timescale 1ns/1ps
module ccs_regs (
  // Clocking
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Wishbone
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] dat_w,
  output logic [31:0] dat_r,
  output logic ack,
  // Core
  ccs_ctrl_if.regs ctl
);
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic owd_dis_reg;
  logic owd_dis_next;
  logic irq_reg;
  logic irq_next;
  logic take;
  always_comb
  begin
    take = ce && cyc && stb && !ack_reg;
    ack_next = ce ? take : ack_reg;
    dat_next = dat_reg;
    owd_dis_next = owd_dis_reg;
    irq_next = irq_reg;
    if (take && we && sel[0] && adr == ccs_pkg::SYS_CFG_OFS)
      owd_dis_next = dat_w[ccs_pkg::OWD_DISABLE_BIT];
    if (take && we && sel[0] && adr == ccs_pkg::STATUS_OFS &&
        dat_w[ccs_pkg::STAT_IRQ_BIT])
      irq_next = 1'b0;
    // A failure in the clearing cycle must not be lost, so set wins.
    if (ce && ctl.fail_event)
      irq_next = 1'b1;
    if (take && !we)
    begin
      dat_next = 32'h0;
      if (adr == ccs_pkg::SYS_CFG_OFS)
        dat_next[ccs_pkg::OWD_DISABLE_BIT] = owd_dis_reg;
      else if (adr == ccs_pkg::STATUS_OFS)
      begin
        dat_next[ccs_pkg::STAT_MODE_LSB +: 3] = ctl.mode;
        dat_next[ccs_pkg::STAT_FAILED_BIT] = ctl.failed;
        dat_next[ccs_pkg::STAT_PLL_BIT] = ctl.pll_on;
        dat_next[ccs_pkg::STAT_IRQ_BIT] = irq_reg;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      owd_dis_reg <= ccs_pkg::SYS_CFG_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      owd_dis_reg <= owd_dis_next;
      irq_reg <= irq_next;
    end
  end
  assign ack = ack_reg;
  assign dat_r = dat_reg;
  assign ctl.owd_disable = owd_dis_reg;
  assign ctl.irq_flag = irq_reg;
endmodule // ccs_regs

// file: src/ccs_top.sv
// CPU clock source selection, PLL model and oscillator watchdog.
`timescale 1ns/1ps
module ccs_top (
  // Clocking
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // Pins
  input wire logic CLOCK_INPUT_PIN,
  input wire logic [2:0] CLOCK_CONFIG_PINS,
  // Wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Clock outputs
  output logic CPU_CLK,
  output logic CPU_CLK_EDGE,
  output logic PLL_ON,
  output logic OSC_FAIL_IRQ
);
  // ****************************************
  // Synchronisers and register slave
  // ****************************************
  ccs_ctrl_if ctl ();
  logic xtal_s;
  logic [2:0] cfg_s;
  ccs_sync #(.W(4)) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .d({CLOCK_INPUT_PIN, CLOCK_CONFIG_PINS}),
    .q({xtal_s, cfg_s})
  );
  ccs_regs u_regs (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .adr(WB_ADR_I),
    .sel(WB_SEL_I),
    .dat_w(WB_DAT_I),
    .dat_r(WB_DAT_O),
    .ack(WB_ACK_O),
    .ctl(ctl)
  );
  // ****************************************
  // State
  // ****************************************
  ccs_pkg::ccs_src_t src_reg, src_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [2:0] mode_reg, mode_next;
  logic xtal_d_reg, xtal_d_next;
  logic [2:0] free_cnt_reg, free_cnt_next;
  logic free_clk_reg, free_clk_next;
  logic [4:0] wd_reg, wd_next;
  logic failed_reg, failed_next;
  logic fail_ev_reg, fail_ev_next;
  logic [15:0] meas_reg, meas_next;
  logic [15:0] period_reg, period_next;
  logic [16:0] acc_reg, acc_next;
  logic [2:0] trans_reg, trans_next;
  logic pll_clk_reg, pll_clk_next;
  logic presc_reg, presc_next;
  logic cpu_reg, cpu_next;
  logic edge_reg, edge_next;
  logic xtal_edge, xtal_rise, osc_mode, wd_act, pll_on;
  logic free_tick, free_fall, resync;
  logic [16:0] acc_sum;
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    xtal_edge = xtal_s ^ xtal_d_reg;
    xtal_rise = xtal_s && !xtal_d_reg;
    osc_mode = mode_reg == ccs_pkg::CFG_PRESC ||
               mode_reg == ccs_pkg::CFG_DIRECT;
    wd_act = src_reg != ccs_pkg::SRC_HOLD && osc_mode &&
             !ctl.owd_disable && !failed_reg;
    pll_on = src_reg == ccs_pkg::SRC_PLL || failed_reg ||
             wd_act;
    free_tick = 1'b0;
    free_fall = 1'b0;
    resync = 1'b0;
    acc_sum = 17'h0;
    src_next = src_reg;
    strap_cnt_next = strap_cnt_reg;
    mode_next = mode_reg;
    xtal_d_next = xtal_s;
    free_cnt_next = 3'h0;
    free_clk_next = 1'b0;
    wd_next = 5'h0;
    failed_next = failed_reg;
    fail_ev_next = 1'b0;
    meas_next = meas_reg;
    period_next = period_reg;
    acc_next = acc_reg;
    trans_next = trans_reg;
    pll_clk_next = pll_clk_reg;
    presc_next = presc_reg;
    cpu_next = cpu_reg;
    // The free-running PLL clock runs only while something needs it.
    if (wd_act || failed_reg)
    begin
      free_clk_next = free_clk_reg;
      free_cnt_next = free_cnt_reg + 3'h1;
      if (free_cnt_reg == ccs_pkg::PLL_FREE_HALF_CYC - 3'h1)
      begin
        free_cnt_next = 3'h0;
        free_clk_next = !free_clk_reg;
        free_tick = !free_clk_reg;
        free_fall = free_clk_reg;
      end
    end
    if (wd_act)
    begin
      if (xtal_edge)
        wd_next = 5'h0;
      else if (free_tick)
        wd_next = wd_reg + 5'h1;
      else
        wd_next = wd_reg;
      if (wd_next == ccs_pkg::WD_OVERFLOW)
      begin
        failed_next = 1'b1;
        fail_ev_next = 1'b1;
        wd_next = 5'h0;
      end
    end
    // Period measurement and rate accumulator of the PLL model.
    if (src_reg == ccs_pkg::SRC_PLL)
    begin
      meas_next = (meas_reg == 16'hffff) ? meas_reg : meas_reg + 16'h1;
      if (xtal_rise)
      begin
        period_next = meas_next;
        meas_next = 16'h0;
      end
      acc_sum = acc_reg + {13'h0, ccs_pkg::ccs_mult2(mode_reg)};
      acc_next = acc_sum;
      if (period_reg != 16'h0 && acc_sum >= {1'b0, period_reg})
      begin
        acc_next = acc_sum - {1'b0, period_reg};
        pll_clk_next = !pll_clk_reg;
      end
      if (xtal_edge)
      begin
        trans_next = trans_reg + 3'h1;
        if (trans_next >= ccs_pkg::ccs_resync(mode_reg))
        begin
          resync = 1'b1;
          trans_next = 3'h0;
          acc_next = 17'h0;
        end
      end
    end
    if (xtal_rise && src_reg == ccs_pkg::SRC_OSC)
      presc_next = !presc_reg;
    case (src_reg)
      ccs_pkg::SRC_HOLD:
      begin
        cpu_next = 1'b0;
        strap_cnt_next = strap_cnt_reg + 2'h1;
        // The pins are read once the synchroniser has settled.
        if (strap_cnt_reg == ccs_pkg::STRAP_DELAY)
        begin
          mode_next = cfg_s;
          src_next = (cfg_s == ccs_pkg::CFG_PRESC ||
                      cfg_s == ccs_pkg::CFG_DIRECT) ?
                     ccs_pkg::SRC_OSC : ccs_pkg::SRC_PLL;
        end
      end
      ccs_pkg::SRC_OSC:
      begin
        if (mode_reg == ccs_pkg::CFG_PRESC)
          cpu_next = presc_next;
        else
          cpu_next = xtal_s;
        // Hand over only as the free clock falls, so no pulse is cut.
        if (failed_reg && free_fall)
        begin
          src_next = ccs_pkg::SRC_FREE;
          cpu_next = 1'b0;
        end
      end
      ccs_pkg::SRC_PLL:
        cpu_next = pll_clk_next;
      ccs_pkg::SRC_FREE:
        cpu_next = free_clk_next;
      default:
        src_next = ccs_pkg::SRC_HOLD;
    endcase
    edge_next = cpu_next != cpu_reg;
    if (!CE)
    begin
      src_next = src_reg;
      strap_cnt_next = strap_cnt_reg;
      mode_next = mode_reg;
      xtal_d_next = xtal_d_reg;
      free_cnt_next = free_cnt_reg;
      free_clk_next = free_clk_reg;
      wd_next = wd_reg;
      failed_next = failed_reg;
      fail_ev_next = fail_ev_reg;
      meas_next = meas_reg;
      period_next = period_reg;
      acc_next = acc_reg;
      trans_next = trans_reg;
      pll_clk_next = pll_clk_reg;
      presc_next = presc_reg;
      cpu_next = cpu_reg;
      edge_next = edge_reg;
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      src_reg <= ccs_pkg::SRC_HOLD;
      strap_cnt_reg <= 2'h0;
      mode_reg <= ccs_pkg::CFG_RESET;
      xtal_d_reg <= 1'b0;
      free_cnt_reg <= 3'h0;
      free_clk_reg <= 1'b0;
      wd_reg <= 5'h0;
      failed_reg <= 1'b0;
      fail_ev_reg <= 1'b0;
      meas_reg <= 16'h0;
      period_reg <= 16'h0;
      acc_reg <= 17'h0;
      trans_reg <= 3'h0;
      pll_clk_reg <= 1'b0;
      presc_reg <= 1'b0;
      cpu_reg <= 1'b0;
      edge_reg <= 1'b0;
    end
    else
    begin
      src_reg <= src_next;
      strap_cnt_reg <= strap_cnt_next;
      mode_reg <= mode_next;
      xtal_d_reg <= xtal_d_next;
      free_cnt_reg <= free_cnt_next;
      free_clk_reg <= free_clk_next;
      wd_reg <= wd_next;
      failed_reg <= failed_next;
      fail_ev_reg <= fail_ev_next;
      meas_reg <= meas_next;
      period_reg <= period_next;
      acc_reg <= acc_next;
      trans_reg <= trans_next;
      pll_clk_reg <= pll_clk_next;
      presc_reg <= presc_next;
      cpu_reg <= cpu_next;
      edge_reg <= edge_next;
    end
  end
  assign ctl.fail_event = fail_ev_reg;
  assign ctl.failed = failed_reg;
  assign ctl.pll_on = pll_on;
  assign ctl.mode = mode_reg;
  assign CPU_CLK = cpu_reg;
  assign CPU_CLK_EDGE = edge_reg;
  assign PLL_ON = pll_on;
  assign OSC_FAIL_IRQ = ctl.irq_flag;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_overflow;
    CE && wd_act && wd_reg == 5'hf && free_tick && !xtal_edge;
  endsequence
  sequence s_switched;
    ##[1:40] (src_reg == ccs_pkg::SRC_FREE);
  endsequence
  a_strap_mode_hold: assert property (
    src_reg != ccs_pkg::SRC_HOLD |=> $stable(mode_reg))
    else $error("Clock mode changed after strap capture.");
  a_presc_half_period: assert property (
    CE && src_reg == ccs_pkg::SRC_OSC && mode_reg == ccs_pkg::CFG_PRESC
    && !failed_reg |-> ##1 (edge_reg == $past(xtal_rise)))
    else $error("Prescaler edge not on an input rising edge.");
  a_direct_follow: assert property (
    CE && src_reg == ccs_pkg::SRC_OSC && mode_reg == ccs_pkg::CFG_DIRECT
    && !failed_reg && !free_fall |=> cpu_reg == $past(xtal_s))
    else $error("Direct drive clock does not follow the input.");
  a_pll_power: assert property (
    src_reg == ccs_pkg::SRC_OSC && ctl.owd_disable && !failed_reg
    |-> !pll_on)
    else $error("PLL left on with watchdog disabled.");
  a_pll_resync: assert property (
    CE && resync |=> acc_reg == 17'h0 && trans_reg == 3'h0)
    else $error("PLL accumulator not resynchronised.");
  a_edge_pulse: assert property (
    CE |=> edge_reg == (cpu_reg != $past(cpu_reg)))
    else $error("Edge pulse does not match a CPU clock edge.");
  a_wd_clear: assert property (
    CE && wd_act && xtal_edge |=> wd_reg == 5'h0 && !failed_reg)
    else $error("Watchdog counter not cleared by a transition.");
  a_wd_mode_only: assert property (
    !osc_mode |-> wd_reg == 5'h0 && !failed_reg)
    else $error("Watchdog active outside direct modes.");
  a_wd_enabled: assert property (
    src_reg == ccs_pkg::SRC_HOLD |-> !ctl.owd_disable)
    else $error("Watchdog not enabled after reset.");
  a_fail_detect: assert property (
    s_overflow |=> failed_reg && fail_ev_reg ##1 ctl.irq_flag)
    else $error("Overflow did not raise the failure.");
  a_fail_switch: assert property (
    disable iff (!ARST_N || !CE) $rose(failed_reg) |-> s_switched)
    else $error("CPU clock not moved to the free clock.");
  a_fail_sticky: assert property (
    failed_reg |=> failed_reg &&
    (src_reg != ccs_pkg::SRC_OSC || $past(src_reg) == ccs_pkg::SRC_OSC))
    else $error("Failover state was left.");
  a_switch_no_glitch: assert property (
    disable iff (!ARST_N || !CE)
    $changed(src_reg) && src_reg == ccs_pkg::SRC_FREE |->
    !cpu_reg [*2])
    else $error("Shortened pulse at the failover switch.");
endmodule // ccs_top

// file: bench/ccs_osc_model.sv
// Behavioural external oscillator that drives the clock input pin.
`timescale 1ns/1ps
module ccs_osc_model (
  // Clocking
  input wire logic clk,
  // Control
  input wire logic run,
  input wire logic [7:0] hi_cyc,
  input wire logic [7:0] lo_cyc,
  // Pin
  output logic pin
);
  logic [7:0] cnt;
  // Edges fall on the falling system clock edge, so that no run length
  // depends on which process the simulator runs first.
  // A stopped oscillator freezes at its last level, as a dead crystal does.
  initial
  begin
    pin = 1'b0;
    cnt = 8'h00;
  end
  always @(negedge clk)
  begin
    if (run === 1'b1)
    begin
      if (cnt + 8'h01 >= (pin ? hi_cyc : lo_cyc))
      begin
        pin <= ~pin;
        cnt <= 8'h00;
      end
      else
        cnt <= cnt + 8'h01;
    end
  end
endmodule // ccs_osc_model

// file: bench/testbench.sv
// Self-checking bench of the CPU clock select block.
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, osc_run, cyc, stb, we, ack, pin, ce, ce_seen;
  logic [3:0] sel;
  logic cpu_clk, cpu_edge, pll_on, irq, cpu_prev;
  logic [2:0] cfg;
  logic [7:0] adr, hi, lo, ua;
  logic [31:0] dw, dr, rd, seed;
  logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
  int fails, cmp_count, run_len, hi_run, lo_run, min_run, edges;
  int edge_bad, cyc_n, last_pin, n;
  ccs_top dut_u (.CLK(clk), .ARST_N(arst_n), .CE(ce),
    .CLOCK_INPUT_PIN(pin), .CLOCK_CONFIG_PINS(cfg), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .CPU_CLK(cpu_clk),
    .CPU_CLK_EDGE(cpu_edge), .PLL_ON(pll_on), .OSC_FAIL_IRQ(irq));
  ccs_osc_model osc_u (.clk(clk), .run(osc_run), .hi_cyc(hi),
    .lo_cyc(lo), .pin(pin));
  // ****************************************
  // Clock and monitors
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc_n++;
  always @(posedge clk) ce_seen <= ce;
  always @(pin) last_pin = cyc_n;
  // Run lengths are measured on the falling edge, where outputs are settled.
  always @(negedge clk)
  begin
    if (cpu_clk !== cpu_prev)
    begin
      if (cpu_clk === 1'b0) hi_run = run_len;
      else lo_run = run_len;
      if (run_len < min_run) min_run = run_len;
      run_len = 1;
      edges++;
    end
    else run_len++;
    if (arst_n === 1'b1 && ce_seen === 1'b1 &&
        cpu_edge !== (cpu_clk !== cpu_prev)) edge_bad++;
    cpu_prev = cpu_clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  function automatic logic [31:0] stat(input logic [2:0] m,
    input logic f, input logic p, input logic i);
    stat = {26'h0, i, p, f, m};
  endfunction
  function automatic int mult2(input logic [2:0] c);
    case (c)
      3'h7: mult2 = 8;
      3'h6: mult2 = 6;
      3'h5: mult2 = 4;
      3'h4: mult2 = 10;
      3'h2: mult2 = 3;
      default: mult2 = 5;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo_v, input int hi_v);
    cmp_count++;
    if (got < lo_v || got > hi_v)
    begin
      fails++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, got,
        lo_v, hi_v);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dw <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rst(input logic [2:0] code);
    @(posedge clk);
    arst_n <= 1'b0;
    cfg <= code;
    osc_run <= 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  task automatic rnd_osc();
    seed = lfsr(seed);
    hi <= 8'h03 + {5'h00, seed[2:0]};
    seed = lfsr(seed);
    lo <= 8'h03 + {5'h00, seed[2:0]};
  endtask
  task automatic meas(input int c);
    @(posedge clk);
    edges = 0;
    repeat (c) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    #2000000;
    fails++;
    $display("MISMATCH at %0t: run did not finish", $time);
    wrap_up();
  end
  initial
  begin
    arst_n = 1'b0;
    cfg = 3'h7;
    osc_run = 1'b0;
    ce = 1'b1;
    sel = 4'h0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dw = 32'h0;
    hi = 8'h14;
    lo = 8'h14;
    seed = 32'h967e;
    cpu_prev = 1'b0;
    min_run = 1000;
    rnd_osc();
    rst(3'h1);
    wb(1'b0, ccs_pkg::STATUS_OFS, 32'h0);
    chk(rd, stat(3'h1, 1'b0, 1'b1, 1'b0));
    meas(300);
    chk(hi_run, {24'h0, hi} + {24'h0, lo});
    chk(lo_run, {24'h0, hi} + {24'h0, lo});
    @(posedge clk);
    osc_run <= 1'b0;
    min_run = 1000;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk_rng(cyc_n - last_pin, 62, 74);
    meas(80);
    chk_rng(min_run, 2, 1000);
    chk_rng(edges, 39, 41);
    wb(1'b0, ccs_pkg::STATUS_OFS, 32'h0);
    chk(rd, stat(3'h1, 1'b1, 1'b1, 1'b1));
    osc_run <= 1'b1;
    wb(1'b1, ccs_pkg::SYS_CFG_OFS, 32'h10);
    meas(80);
    chk(hi_run, 32'h2);
    chk(lo_run, 32'h2);
    // A low clock enable must freeze the generated clock as it stands.
    ce <= 1'b0;
    meas(20);
    chk_rng(edges, 0, 0);
    ce <= 1'b1;
    wb(1'b1, ccs_pkg::STATUS_OFS, 32'h20);
    chk({31'h0, irq}, 32'h0);
    repeat (2)
    begin
      rnd_osc();
      rst(3'h3);
      wb(1'b0, ccs_pkg::SYS_CFG_OFS, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, ccs_pkg::STATUS_OFS, 32'h0);
      chk(rd, stat(3'h3, 1'b0, 1'b1, 1'b0));
      meas(300);
      chk(hi_run, {24'h0, hi});
      chk(hi_run + lo_run, {24'h0, hi} + {24'h0, lo});
    end
    wb(1'b1, ccs_pkg::SYS_CFG_OFS, 32'h10);
    wb(1'b0, ccs_pkg::SYS_CFG_OFS, 32'h0);
    chk(rd, 32'h10);
    chk({31'h0, pll_on}, 32'h0);
    osc_run <= 1'b0;
    repeat (200) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, ccs_pkg::STATUS_OFS, 32'h0);
    chk(rd, stat(3'h3, 1'b0, 1'b0, 1'b0));
    seed = lfsr(seed);
    ua = 8'h08 | (seed[7:0] & 8'hf8);
    wb(1'b1, ua, seed);
    wb(1'b0, ua, 32'h0);
    chk(rd, 32'h0);
    hi <= 8'h14;
    lo <= 8'h14;
    for (int k = 0; k < 6; k++)
    begin
      rst(codes[k]);
      wb(1'b0, ccs_pkg::STATUS_OFS, 32'h0);
      chk(rd, stat(codes[k], 1'b0, 1'b1, 1'b0));
      repeat (400) @(posedge clk);
      meas(2400);
      chk_rng(edges, 60 * mult2(codes[k]) - 4,
        60 * mult2(codes[k]) + 4);
    end
    osc_run <= 1'b0;
    repeat (300) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    chk_rng(edge_bad, 0, 0);
    wrap_up();
  end
endmodule // testbench
